// *** rcss_defs.vh ***
/*
 * Constants for the reset and clock start sequencer: clock source codes,
 * select field positions, delay figures and derived cycle counts.
 * Assumes a 20 MHz system clock; included by its bare name.
 */
`ifndef RCSS_DEFS_VH
`define RCSS_DEFS_VH

// ----------------------------------------------------------------------------
// Clock source codes (3-bit select field)
// ----------------------------------------------------------------------------
`define RCSS_SRC_FASTRC 3'h0
`define RCSS_SRC_FRCPLL 3'h1
`define RCSS_SRC_PRI 3'h2
`define RCSS_SRC_PRIPLL 3'h3
`define RCSS_SRC_SECOSC 3'h4
`define RCSS_SRC_LOWRC 3'h5
`define RCSS_SRC_EXTCLK 3'h6
`define RCSS_SRC_FRCDIV 3'h7
`define RCSS_SEL_W 3
// Field position of current select inside the oscillator control word
`define RCSS_CUR_SEL_LSB 12
`define RCSS_CUR_SEL_MSB 14
`define RCSS_CFG_SEL_LSB 0
`define RCSS_CFG_SEL_MSB 2

// ----------------------------------------------------------------------------
// Timing figures and derived cycle counts
// ----------------------------------------------------------------------------
`define RCSS_CLK_HZ 20000000
`define RCSS_PUT_MS 64
`define RCSS_PUT_CYC (`RCSS_PUT_MS * (`RCSS_CLK_HZ / 1000))
`define RCSS_PON_US 10
`define RCSS_PON_CYC (`RCSS_PON_US * (`RCSS_CLK_HZ / 1000000))
`define RCSS_TRC_US 15
`define RCSS_TRC_CYC (`RCSS_TRC_US * (`RCSS_CLK_HZ / 1000000))
`define RCSS_TLOCK_US 128
`define RCSS_TLOCK_CYC (`RCSS_TLOCK_US * (`RCSS_CLK_HZ / 1000000))
`define RCSS_TFSCM_US 2
`define RCSS_TFSCM_CYC (`RCSS_TFSCM_US * (`RCSS_CLK_HZ / 1000000))
`define RCSS_START_PERIODS 11'h400
`define RCSS_START_W 10

`endif

// *** rcss_counter.v ***
/*
 * Loadable down counter with a done flag, used for each start-up delay.
 * Assumes synchronous active-low reset and a one-cycle load strobe.
 */
`timescale 1ns/1ps
module rcss_counter #(
    parameter W = 24
) (
    input wire clock,
    input wire resetn,
    input wire load,
    input wire [W-1:0] load_value,
    input wire tick,
    output reg done
);
    reg [W-1:0] count;

    // Count down on tick; done once zero is reached
    always @(posedge clock) begin
        if (!resetn) begin
            count <= {W{1'b0}};
            done <= 1'b0;
        end else if (load) begin
            count <= load_value;
            done <= (load_value == {W{1'b0}});
        end else if (!done) begin
            if (count == {W{1'b0}}) begin
                done <= 1'b1;
            end else if (tick) begin
                count <= count - {{(W-1){1'b0}}, 1'b1};
                if (count == {{(W-1){1'b0}}, 1'b1}) begin
                    done <= 1'b1;
                end
            end
        end
    end
endmodule

// *** rcss_sequencer.v ***
/*
 * Reset and clock start sequencer: takes a reset event, chooses the clock
 * source, holds system reset for the power-on and power-up delays, waits
 * alongside them for oscillator start and then PLL lock, then enables code run;
 * the fail-safe clock monitor starts a fixed delay after reset release.
 * Assumes all inputs synchronous to clock; osc_tick pulses once per
 * selected oscillator period.
 */
`timescale 1ns/1ps
`include "rcss_defs.vh"
module rcss_sequencer #(
    parameter PUT_CYC = `RCSS_PUT_CYC,
    parameter PON_CYC = `RCSS_PON_CYC,
    parameter TRC_CYC = `RCSS_TRC_CYC,
    parameter TLOCK_CYC = `RCSS_TLOCK_CYC,
    parameter TFSCM_CYC = `RCSS_TFSCM_CYC,
    parameter CW = 24
) (
    input wire clock,
    input wire resetn,
    input wire por_event,
    input wire bor_event,
    input wire external_reset_pin,
    input wire watchdog_timeout_reset,
    input wire software_reset,
    input wire clock_switch_enable,
    input wire power_up_timer_enable,
    input wire two_speed_enable,
    input wire [7:0] config_osc_select_word,
    input wire [15:0] osc_control_reg,
    input wire osc_tick,
    output reg system_reset_out,
    output reg run_enable,
    output reg fail_safe_clock_monitor,
    output reg [`RCSS_SEL_W-1:0] clock_source,
    output reg start_on_frc
);
    // ------------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------------
    // IDLE only follows the block's own reset and loads zero delays.
    // HOLD keeps system reset asserted while the reset delay runs.
    // WAITCLK has reset released but waits for the clock to be usable.
    // RUN lets code execute until the next reset event restarts all.
    localparam ST_IDLE = 4'b0001;
    localparam ST_HOLD = 4'b0010;
    localparam ST_WAITCLK = 4'b0100;
    localparam ST_RUN = 4'b1000;

    reg [3:0] state;
    reg [3:0] next_state;
    reg load;
    reg start_load;
    reg mon_load;
    reg [CW-1:0] rst_value;
    reg [CW-1:0] clk_value;
    reg [`RCSS_SEL_W-1:0] next_source;
    reg use_start;
    reg lock_after_start;
    wire rst_done;
    wire clk_done;
    wire start_done;
    wire mon_done;
    wire clk_tick;
    wire any_reset;
    wire [`RCSS_SEL_W-1:0] cfg_sel;
    wire [`RCSS_SEL_W-1:0] cur_sel;
    wire [CW-1:0] put_len;
    wire [`RCSS_START_W:0] start_len;

    // Any of the five reset kinds restarts the whole sequence
    assign any_reset = por_event | bor_event | external_reset_pin |
                       watchdog_timeout_reset | software_reset;
    assign cfg_sel = config_osc_select_word[`RCSS_CFG_SEL_MSB:`RCSS_CFG_SEL_LSB];
    assign cur_sel = osc_control_reg[`RCSS_CUR_SEL_MSB:`RCSS_CUR_SEL_LSB];
    // Power-up timer length from configuration
    assign put_len = power_up_timer_enable ? PUT_CYC[CW-1:0] : {CW{1'b0}};
    // Start-up timer length, only for crystal and secondary sources
    assign start_len = use_start ? `RCSS_START_PERIODS : 11'h000;
    // PLL lock wait on a crystal only begins once the crystal has started
    assign clk_tick = !lock_after_start | start_done;

    // ------------------------------------------------------------------------
    // Source choice and delay lengths for the reset being taken
    // ------------------------------------------------------------------------
    // Picks the source and both delays combinationally
    always @* begin
        if (!clock_switch_enable || por_event || bor_event) begin
            next_source = cfg_sel;
        end else begin
            next_source = cur_sel;
        end
        if (por_event) begin
            rst_value = PON_CYC[CW-1:0] + put_len;
        end else if (bor_event) begin
            rst_value = put_len;
        end else begin
            rst_value = {CW{1'b0}};
        end
        use_start = 1'b0;
        clk_value = {CW{1'b0}};
        // Only power-on and brown-out owe a clock delay
        if (!(por_event || bor_event)) begin
            clk_value = {CW{1'b0}};
        end else if (two_speed_enable) begin
            clk_value = TRC_CYC[CW-1:0];
        end else begin
            case (next_source)
                `RCSS_SRC_EXTCLK: clk_value = {CW{1'b0}};
                `RCSS_SRC_FASTRC, `RCSS_SRC_FRCDIV, `RCSS_SRC_LOWRC: begin
                    clk_value = TRC_CYC[CW-1:0];
                end
                `RCSS_SRC_FRCPLL: begin
                    clk_value = TRC_CYC[CW-1:0] + TLOCK_CYC[CW-1:0];
                end
                `RCSS_SRC_PRIPLL: begin
                    // Lock time is added after the start-up count
                    use_start = 1'b1;
                    clk_value = TLOCK_CYC[CW-1:0];
                end
                `RCSS_SRC_PRI, `RCSS_SRC_SECOSC: use_start = 1'b1;
                default: clk_value = {CW{1'b0}};
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Delay counters
    // ------------------------------------------------------------------------
    // System reset delay
    rcss_counter #(.W(CW)) u_rst (
        .clock(clock), .resetn(resetn), .load(load), .load_value(rst_value),
        .tick(1'b1), .done(rst_done)
    );
    // RC start-up and PLL lock wait, runs alongside the reset delay
    rcss_counter #(.W(CW)) u_clk (
        .clock(clock), .resetn(resetn), .load(load), .load_value(clk_value),
        .tick(clk_tick), .done(clk_done)
    );
    // Oscillator start-up timer, counts oscillator periods
    rcss_counter #(.W(`RCSS_START_W + 1)) u_start (
        .clock(clock), .resetn(resetn), .load(start_load),
        .load_value(start_len),
        .tick(osc_tick), .done(start_done)
    );
    // Fail-safe monitor delay from reset release
    rcss_counter #(.W(CW)) u_mon (
        .clock(clock), .resetn(resetn), .load(mon_load),
        .load_value(TFSCM_CYC[CW-1:0]), .tick(1'b1), .done(mon_done)
    );

    // ------------------------------------------------------------------------
    // Sequence control
    // ------------------------------------------------------------------------
    // Next state and counter loads
    always @* begin
        next_state = state;
        load = 1'b0;
        start_load = 1'b0;
        mon_load = 1'b0;
        case (state)
            ST_IDLE: begin
                load = 1'b1;
                start_load = 1'b1;
                next_state = ST_HOLD;
            end
            ST_HOLD: begin
                if (rst_done) begin
                    mon_load = 1'b1;
                    next_state = ST_WAITCLK;
                end
            end
            ST_WAITCLK: begin
                if (clk_done && start_done) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: next_state = ST_RUN;
            default: next_state = ST_IDLE;
        endcase
        // A new event aborts whatever runs and reloads every delay but the monitor delay
        if (any_reset) begin
            load = 1'b1;
            start_load = 1'b1;
            mon_load = 1'b0;
            next_state = ST_HOLD;
        end
    end

    // Remembers whether the lock wait must follow the start-up count
    always @(posedge clock) begin
        if (!resetn) begin
            lock_after_start <= 1'b0;
        end else if (load) begin
            lock_after_start <= use_start && (next_source == `RCSS_SRC_PRIPLL);
        end
    end

    // State, source register and outputs
    always @(posedge clock) begin
        if (!resetn) begin
            state <= ST_IDLE;
            clock_source <= `RCSS_SRC_FASTRC;
            start_on_frc <= 1'b0;
            system_reset_out <= 1'b1;
            run_enable <= 1'b0;
            fail_safe_clock_monitor <= 1'b0;
        end else begin
            state <= next_state;
            if (load) begin
                clock_source <= next_source;
                start_on_frc <= two_speed_enable & (por_event | bor_event);
            end
            system_reset_out <= (next_state == ST_HOLD);
            run_enable <= (next_state == ST_RUN);
            // Stale done from an earlier sequence is masked outside the run states
            fail_safe_clock_monitor <= mon_done && !load &&
                                       (state == ST_WAITCLK || state == ST_RUN);
        end
    end
endmodule

// *** rcss_sequencer_props.sv ***
/* Assertions on the ports of the start sequencer.
   Assumes bench parameters; bound to every rcss_sequencer. */
`timescale 1ns/1ps
module rcss_sequencer_props #(parameter PUT_CYC = 20, parameter PON_CYC = 5) (
    input wire clock,
    input wire resetn,
    input wire por_event,
    input wire bor_event,
    input wire external_reset_pin,
    input wire watchdog_timeout_reset,
    input wire software_reset,
    input wire clock_switch_enable,
    input wire power_up_timer_enable,
    input wire two_speed_enable,
    input wire [7:0] config_osc_select_word,
    input wire [15:0] osc_control_reg,
    input wire osc_tick,
    input wire system_reset_out,
    input wire run_enable,
    input wire fail_safe_clock_monitor,
    input wire [2:0] clock_source,
    input wire start_on_frc
);
    // ----------------------------------------
    // Helper counters
    // ----------------------------------------
    reg [31:0] cnt, need, ticks;
    reg pb;
    wire ev;
    wire [31:0] pw;
    assign ev = por_event | bor_event | external_reset_pin |
                watchdog_timeout_reset | software_reset;
    assign pw = power_up_timer_enable ? PUT_CYC : 0;
    // Cycles and ticks since the last event, and the hold it owes
    always @(posedge clock) begin
        if (!resetn || ev) begin
            cnt <= 0;
            ticks <= 0;
            need <= !resetn ? 0 : por_event ? PON_CYC + pw : bor_event ? pw : 0;
            pb <= resetn & (por_event | bor_event);
        end else begin
            cnt <= cnt + 1;
            ticks <= ticks + osc_tick;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    a_run_released: assert property (run_enable |-> !system_reset_out)
        else $error("run while reset held");
    a_monitor_wait: assert property (
        $fell(system_reset_out) |-> !fail_safe_clock_monitor [*4])
        else $error("monitor started early");
    a_monitor_start: assert property (
        $fell(system_reset_out) |->
        ##[1:12] (fail_safe_clock_monitor || system_reset_out))
        else $error("monitor never started");
    a_reset_taken: assert property (ev |=> system_reset_out)
        else $error("reset not asserted");
    a_reset_min: assert property (
        $fell(system_reset_out) |-> cnt >= need)
        else $error("reset released early");
    a_reset_max: assert property (
        system_reset_out && !ev |-> cnt <= need + 6)
        else $error("reset held too long");
    a_src_config: assert property (
        por_event || bor_event |=>
        clock_source == $past(config_osc_select_word[2:0]))
        else $error("source not from config");
    a_src_keep: assert property (
        clock_switch_enable && ev && !por_event && !bor_event |=>
        clock_source == $past(osc_control_reg[14:12]))
        else $error("source not kept");
    a_src_noswitch: assert property (
        !clock_switch_enable && ev |=>
        clock_source == $past(config_osc_select_word[2:0]))
        else $error("source not from config");
    a_frc_start: assert property (
        two_speed_enable && por_event && config_osc_select_word[2:0] == 3'h2 |=>
        start_on_frc)
        else $error("no fast rc start");
    a_start_count: assert property (
        $rose(run_enable) && pb && clock_source == 3'h2 && !start_on_frc |->
        ticks >= 1024)
        else $error("crystal released early");
endmodule
bind rcss_sequencer rcss_sequencer_props #(.PUT_CYC(PUT_CYC), .PON_CYC(PON_CYC)) u_props (
    .clock(clock), .resetn(resetn), .por_event(por_event), .bor_event(bor_event),
    .external_reset_pin(external_reset_pin), .watchdog_timeout_reset(watchdog_timeout_reset),
    .software_reset(software_reset), .clock_switch_enable(clock_switch_enable),
    .power_up_timer_enable(power_up_timer_enable), .two_speed_enable(two_speed_enable),
    .config_osc_select_word(config_osc_select_word), .osc_control_reg(osc_control_reg),
    .osc_tick(osc_tick), .system_reset_out(system_reset_out), .run_enable(run_enable),
    .fail_safe_clock_monitor(fail_safe_clock_monitor), .clock_source(clock_source),
    .start_on_frc(start_on_frc));

// *** rcss_osc_model.sv ***
/* Oscillator model: one tick per oscillator period.
   Assumes the bench picks prompt (every cycle) or slow (every third). */
`timescale 1ns/1ps
module rcss_osc_model (
    input wire clock,
    input wire resetn,
    input wire slow,
    output reg osc_tick
);
    // ----------------------------------------
    // Period counter
    // ----------------------------------------
    reg [1:0] ph;
    // No ticks while held in reset
    always @(posedge clock) begin
        if (!resetn) begin
            ph <= 2'h0;
            osc_tick <= 1'b0;
        end else begin
            ph <= (ph == 2'h2 || !slow) ? 2'h0 : ph + 2'h1;
            osc_tick <= (ph == 2'h0);
        end
    end
endmodule

// *** reset_clock_start_sequencer_bench.sv ***
/* Self-checking bench for the start sequencer.
   Assumes shortened delay parameters and the oscillator model. */
`timescale 1ns/1ps
module reset_clock_start_sequencer_bench;
    // ----------------------------------------
    // Stimulus, model and checks
    // ----------------------------------------
    localparam PW = 20, TP = 5, TR = 8, TL = 12, TF = 6;
    reg clock = 0, resetn = 0, cse = 0, pwe = 0, tse = 0, slow = 0;
    reg [4:0] ev = 0;
    reg [7:0] cfg = 0;
    reg [15:0] occ = 0;
    reg [2:0] xs;
    wire osc_tick, srst, run, mon, sfrc;
    wire [2:0] src;
    integer bad_count = 0, compares = 0, cyc = 0, i, t, ft, rt, mt, rd, cd, k, mx;
    rcss_osc_model osc (.clock(clock), .resetn(resetn), .slow(slow), .osc_tick(osc_tick));
    rcss_sequencer #(.PUT_CYC(PW), .PON_CYC(TP), .TRC_CYC(TR), .TLOCK_CYC(TL),
        .TFSCM_CYC(TF)) dut (.clock(clock), .resetn(resetn), .por_event(ev[0]),
        .bor_event(ev[1]), .external_reset_pin(ev[2]), .watchdog_timeout_reset(ev[3]),
        .software_reset(ev[4]), .clock_switch_enable(cse), .power_up_timer_enable(pwe),
        .two_speed_enable(tse), .config_osc_select_word(cfg), .osc_control_reg(occ),
        .osc_tick(osc_tick), .system_reset_out(srst), .run_enable(run),
        .fail_safe_clock_monitor(mon), .clock_source(src), .start_on_frc(sfrc));
    task cmp_val(input string nm, input logic [2:0] e, input logic [2:0] g);
        compares = compares + 1;
        if (g !== e) begin
            bad_count = bad_count + 1;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task cmp_win(input string nm, input integer lo, input integer hi, input integer g);
        compares = compares + 1;
        if (g < lo || g > hi) begin
            bad_count = bad_count + 1;
            $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask
    task final_report;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Clock-source delay after power-on or brown-out, per oscillator period
    function integer cdel(input [2:0] s, input integer per);
        case (s)
            3'h0, 3'h5, 3'h7: cdel = TR;
            3'h1: cdel = TR + TL;
            3'h2, 3'h4: cdel = 1024 * per;
            3'h3: cdel = 1024 * per + TL;
            default: cdel = 0;
        endcase
    endfunction
    initial forever #25 clock = ~clock;
    // Hang guard
    always @(posedge clock) begin
        cyc = cyc + 1;
        if (cyc == 90000) begin
            bad_count = bad_count + 1;
            final_report;
        end
    end
    // Every reset kind against every source, some back to back
    initial begin
        k = $urandom(32'hda903492);
        repeat (4) @(posedge clock);
        resetn <= 1'b1;
        repeat (10) @(posedge clock);
        for (i = 0; i < 40; i = i + 1) begin
            k = i % 5;
            cse <= 1'($urandom);
            pwe <= 1'($urandom);
            slow <= 1'($urandom);
            tse <= (i % 4 == 1);
            cfg <= {5'($urandom), 3'(i)};
            occ <= 16'($urandom);
            if (i % 7 == 3) begin
                @(posedge clock);
                ev <= 5'h01;
            end
            @(posedge clock);
            ev <= 5'h01 << k;
            @(posedge clock);
            ev <= 5'h00;
            rd = k == 0 ? TP + (pwe ? PW : 0) : k == 1 ? (pwe ? PW : 0) : 0;
            cd = k < 2 ? cdel(cfg[2:0], slow ? 3 : 1) : 0;
            mx = rd > cd ? rd : cd;
            xs = (cse && k > 1) ? occ[14:12] : cfg[2:0];
            t = 0;
            ft = -1;
            rt = -1;
            mt = -1;
            while ((mt < 0 || rt < 0) && t < 4000) begin
                @(negedge clock);
                t = t + 1;
                if (t == 1) begin
                    cmp_val("clock source", xs, src);
                    cmp_val("system reset", 3'h1, {2'b00, srst});
                    if (k == 0 && cfg[2:0] == 3'h2)
                        cmp_val("fast rc start", {2'b00, tse}, {2'b00, sfrc});
                end
                if (ft < 0 && srst === 1'b0) ft = t;
                if (rt < 0 && run === 1'b1) rt = t;
                if (mt < 0 && mon === 1'b1) mt = t;
            end
            cmp_win("reset release", rd, rd + 5, ft);
            if (!tse) cmp_win("run start", mx, mx + 12, rt);
            cmp_win("monitor start", ft + TF, ft + TF + 4, mt);
        end
        final_report;
    end
endmodule
